// File: fbib_bridge.v
// Fabric bus interface bridge: region decode, master and slave ports
// How it works
// (R01) Six 256 MB regions, each to one instance
// (R02) Regions 0-2 at 0x3/0x5/0x7 tops
// (R03) Regions 3-5 at 0x8/0x9/0xF tops
// (R04) One assignment vector routes both instances
// (R05) Master ports drive 20-bit byte address
// (R06) Master ports carry 32-bit write/read data
// (R07) Size: byte 00, halfword 01, word 10
// (R08) Trans: idle, busy, nonseq, seq codes
// (R09) Write high, read low on AHB
// (R10) Ready low holds current transfer
// (R11) Slave response high marks an error
// (R12) Lock marks indivisible locked sequence
// (R13) APB master has one select line
// (R14) APB enable low in setup, high after
// (R15) APB write steady through the transfer
// (R16) APB access waits for ready high
// (R17) APB slave error recorded as error
// (R18) Slave port takes 32-bit address/data
// (R19) Slave port ignores transfers without select
// (R20) Slave ready-out low inserts wait states
// (R21) Slave response high on failed transfer
// (R22) Only low 20 address bits forwarded
`timescale 1ns/1ps
`include "fbib_consts.vh"

module fbib_master_port
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Mode: high selects the APB form
   input wire useApb,
   // Request from the processor subsystem
   input wire reqValid,
   input wire [31:0] reqAddr,
   input wire reqWrite,
   input wire [1:0] reqSize,
   input wire [1:0] reqTrans,
   input wire reqLock,
   input wire [31:0] reqWdata,
   output wire reqReady,
   output reg respValid,
   output reg respError,
   output reg [31:0] respRdata,
   // AHB-Lite master toward fabric
   output wire [19:0] ahbAddr,
   output wire [31:0] ahbWdata,
   output wire ahbLock,
   output wire [1:0] ahbSize,
   output wire [1:0] ahbTrans,
   output wire ahbWrite,
   input wire ahbReady,
   input wire ahbResp,
   input wire [31:0] ahbRdata,
   // APB master toward fabric
   output wire [19:0] apbAddr,
   output wire [31:0] apbWdata,
   output wire apbSel,
   output wire apbEnable,
   output wire apbWrite,
   input wire apbReady,
   input wire apbSlvErr,
   input wire [31:0] apbRdata
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_DATA = 3'h2;
   localparam [2:0] ST_SETUP = 3'h3;
   localparam [2:0] ST_ACCESS = 3'h4;

   reg [2:0] state;
   reg [19:0] addrQ;
   reg [31:0] wdataQ;
   reg writeQ;
   reg [1:0] sizeQ;
   reg [1:0] transQ;
   reg lockQ;

   assign reqReady = (state == ST_IDLE);
   assign ahbAddr = addrQ;
   assign ahbWdata = wdataQ;
   assign ahbWrite = writeQ; // [R09]
   assign ahbSize = sizeQ; // [R07]
   assign ahbLock = lockQ; // [R12]
   assign ahbTrans = (state == ST_ADDR) ? transQ : `FBIB_TRANS_IDLE; // [R08]
   assign apbAddr = addrQ; // [R05]
   assign apbWdata = wdataQ; // [R06]
   assign apbWrite = writeQ; // [R15]
   assign apbSel = (state == ST_SETUP) || (state == ST_ACCESS); // [R13]
   assign apbEnable = (state == ST_ACCESS); // [R14]

   always @(posedge clk)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         addrQ <= 20'h00000;
         wdataQ <= 32'h00000000;
         writeQ <= 1'b0;
         sizeQ <= `FBIB_SIZE_BYTE;
         transQ <= `FBIB_TRANS_IDLE;
         lockQ <= 1'b0;
         respValid <= 1'b0;
         respError <= 1'b0;
         respRdata <= 32'h00000000;
      end
      else
      begin
         respValid <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (reqValid && reqTrans[1])
               begin
                  addrQ <= reqAddr[19:0]; // [R22]
                  wdataQ <= reqWdata; // [R06]
                  writeQ <= reqWrite;
                  sizeQ <= reqSize;
                  transQ <= reqTrans;
                  lockQ <= reqLock;
                  state <= useApb ? ST_SETUP : ST_ADDR;
               end
               else if (!reqLock)
                  lockQ <= 1'b0;
            end
            ST_ADDR:
            begin
               if (ahbReady) // [R10]
                  state <= ST_DATA;
            end
            ST_DATA:
            begin
               if (ahbReady) // [R10]
               begin
                  respValid <= 1'b1;
                  respError <= ahbResp; // [R11]
                  respRdata <= ahbRdata;
                  state <= ST_IDLE;
               end
            end
            ST_SETUP:
               state <= ST_ACCESS; // [R14]
            ST_ACCESS:
            begin
               if (apbReady) // [R16]
               begin
                  respValid <= 1'b1;
                  respError <= apbSlvErr; // [R17]
                  respRdata <= apbRdata;
                  state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
endmodule

module fbib_slave_port
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // AHB-Lite slave from fabric master
   input wire hsSel,
   input wire [31:0] hsAddr,
   input wire [31:0] hsWdata,
   input wire hardSlaveLock,
   input wire [1:0] hsSize,
   input wire [1:0] hardSlaveTransferType,
   input wire hsWrite,
   input wire hsReady,
   output reg [31:0] hsRdata,
   output wire hardSlaveReadyOut,
   output wire hardSlaveResponse,
   // Toward subsystem slaves
   output wire subValid,
   output reg [31:0] subAddr,
   output reg subWrite,
   output reg [1:0] subSize,
   output reg subLock,
   output wire [31:0] subWdata,
   input wire subDone,
   input wire subError,
   input wire [31:0] subRdata
);
   localparam [2:0] SS_IDLE = 3'h0;
   localparam [2:0] SS_WAIT = 3'h1;
   localparam [2:0] SS_DONE = 3'h2;
   localparam [2:0] SS_ERR1 = 3'h3;
   localparam [2:0] SS_ERR2 = 3'h4;

   reg [2:0] state;
   wire open;
   wire take;

   assign open = (state == SS_IDLE) || (state == SS_DONE) ||
      (state == SS_ERR2);
   // Address phase counts only with select and a real transfer
   assign take = open && hsSel && hsReady &&
      hardSlaveTransferType[1]; // [R19]
   assign subValid = (state == SS_WAIT);
   assign subWdata = hsWdata; // [R18]
   assign hardSlaveReadyOut = open; // [R20]
   assign hardSlaveResponse = (state == SS_ERR1) ||
      (state == SS_ERR2); // [R21]

   always @(posedge clk)
   begin
      if (rst)
      begin
         state <= SS_IDLE;
         subAddr <= 32'h00000000;
         subWrite <= 1'b0;
         subSize <= `FBIB_SIZE_BYTE;
         subLock <= 1'b0;
         hsRdata <= 32'h00000000;
      end
      else
      begin
         case (state)
            SS_WAIT:
            begin
               if (subDone)
               begin
                  hsRdata <= subRdata;
                  state <= subError ? SS_ERR1 : SS_DONE; // [R21]
               end
            end
            SS_ERR1:
               state <= SS_ERR2;
            SS_IDLE, SS_DONE, SS_ERR2:
            begin
               if (take)
               begin
                  subAddr <= hsAddr; // [R18]
                  subWrite <= hsWrite; // [R09]
                  subSize <= hsSize; // [R07]
                  subLock <= hardSlaveLock; // [R12]
                  state <= SS_WAIT;
               end
               else
                  state <= SS_IDLE;
            end
            default:
               state <= SS_IDLE;
         endcase
      end
   end
endmodule

module fbib_bridge
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Static configuration
   input wire [5:0] regionToSecond,
   input wire [1:0] useApb,
   // Processor subsystem request
   input wire reqValid,
   input wire [31:0] reqAddr,
   input wire reqWrite,
   input wire [1:0] reqSize,
   input wire [1:0] reqTrans,
   input wire reqLock,
   input wire [31:0] reqWdata,
   output wire reqReady,
   output wire respValid,
   output wire respError,
   output wire [31:0] respRdata,
   // AHB-Lite masters, instance 1 in upper half
   output wire [39:0] ahbAddr,
   output wire [63:0] ahbWdata,
   output wire [1:0] ahbLock,
   output wire [3:0] ahbSize,
   output wire [3:0] hardMasterTransferType,
   output wire [1:0] ahbWrite,
   input wire [1:0] ahbReady,
   input wire [1:0] hardMasterResponse,
   input wire [63:0] ahbRdata,
   // APB masters
   output wire [39:0] apbAddr,
   output wire [63:0] apbWdata,
   output wire [1:0] apbSel,
   output wire [1:0] apbEnable,
   output wire [1:0] apbWrite,
   input wire [1:0] apbReady,
   input wire [1:0] periphMasterErrorIn,
   input wire [63:0] apbRdata,
   // AHB-Lite slave ports
   input wire [1:0] hsSel,
   input wire [63:0] hsAddr,
   input wire [63:0] hsWdata,
   input wire [1:0] hardSlaveLock,
   input wire [3:0] hsSize,
   input wire [3:0] hardSlaveTransferType,
   input wire [1:0] hsWrite,
   input wire [1:0] hsReady,
   output wire [63:0] hsRdata,
   output wire [1:0] hardSlaveReadyOut,
   output wire [1:0] hardSlaveResponse,
   // Subsystem side of slave ports
   output wire [1:0] subValid,
   output wire [63:0] subAddr,
   output wire [1:0] subWrite,
   output wire [3:0] subSize,
   output wire [1:0] subLock,
   output wire [63:0] subWdata,
   input wire [1:0] subDone,
   input wire [1:0] subError,
   input wire [63:0] subRdata
);
   reg [5:0] hit;
   reg missResp;
   wire inst1;
   wire mapped;
   wire [1:0] route;
   wire [1:0] portReady;
   wire [1:0] portResp;
   wire [1:0] portErr;
   wire [63:0] portRdata;
   genvar gi;

   always @*
   begin
      hit = 6'h00;
      case (reqAddr[31:28])
         `FBIB_REGION0_TOP: hit[0] = 1'b1; // [R02]
         `FBIB_REGION1_TOP: hit[1] = 1'b1; // [R02]
         `FBIB_REGION2_TOP: hit[2] = 1'b1; // [R02]
         `FBIB_REGION3_TOP: hit[3] = 1'b1; // [R03]
         `FBIB_REGION4_TOP: hit[4] = 1'b1; // [R03]
         `FBIB_REGION5_TOP: hit[5] = 1'b1; // [R03]
         default: hit = 6'h00;
      endcase
   end

   assign mapped = |hit;
   // One vector steers both instances exclusively
   assign inst1 = |(hit & regionToSecond); // [R01] [R04]
   assign route = mapped ? {inst1, ~inst1} : 2'b00; // [R01]
   // Unmapped requests are taken at once and answered with an error
   assign reqReady = mapped ? |(route & portReady) : 1'b1;
   assign respValid = (|portResp) || missResp;
   assign respError = (|(portResp & portErr)) || missResp;
   assign respRdata = portResp[1] ? portRdata[63:32] : portRdata[31:0];

   always @(posedge clk)
   begin
      if (rst)
         missResp <= 1'b0;
      else
         missResp <= reqValid && !mapped;
   end

   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : inst
         fbib_master_port master
         (
            .clk(clk),
            .rst(rst),
            .useApb(useApb[gi]),
            .reqValid(reqValid && route[gi]),
            .reqAddr(reqAddr),
            .reqWrite(reqWrite),
            .reqSize(reqSize),
            .reqTrans(reqTrans),
            .reqLock(reqLock),
            .reqWdata(reqWdata),
            .reqReady(portReady[gi]),
            .respValid(portResp[gi]),
            .respError(portErr[gi]),
            .respRdata(portRdata[32*gi+31:32*gi]),
            .ahbAddr(ahbAddr[20*gi+19:20*gi]),
            .ahbWdata(ahbWdata[32*gi+31:32*gi]),
            .ahbLock(ahbLock[gi]),
            .ahbSize(ahbSize[2*gi+1:2*gi]),
            .ahbTrans(hardMasterTransferType[2*gi+1:2*gi]),
            .ahbWrite(ahbWrite[gi]),
            .ahbReady(ahbReady[gi]),
            .ahbResp(hardMasterResponse[gi]),
            .ahbRdata(ahbRdata[32*gi+31:32*gi]),
            .apbAddr(apbAddr[20*gi+19:20*gi]),
            .apbWdata(apbWdata[32*gi+31:32*gi]),
            .apbSel(apbSel[gi]),
            .apbEnable(apbEnable[gi]),
            .apbWrite(apbWrite[gi]),
            .apbReady(apbReady[gi]),
            .apbSlvErr(periphMasterErrorIn[gi]),
            .apbRdata(apbRdata[32*gi+31:32*gi])
         );
         fbib_slave_port slave
         (
            .clk(clk),
            .rst(rst),
            .hsSel(hsSel[gi]),
            .hsAddr(hsAddr[32*gi+31:32*gi]),
            .hsWdata(hsWdata[32*gi+31:32*gi]),
            .hardSlaveLock(hardSlaveLock[gi]),
            .hsSize(hsSize[2*gi+1:2*gi]),
            .hardSlaveTransferType(hardSlaveTransferType[2*gi+1:2*gi]),
            .hsWrite(hsWrite[gi]),
            .hsReady(hsReady[gi]),
            .hsRdata(hsRdata[32*gi+31:32*gi]),
            .hardSlaveReadyOut(hardSlaveReadyOut[gi]),
            .hardSlaveResponse(hardSlaveResponse[gi]),
            .subValid(subValid[gi]),
            .subAddr(subAddr[32*gi+31:32*gi]),
            .subWrite(subWrite[gi]),
            .subSize(subSize[2*gi+1:2*gi]),
            .subLock(subLock[gi]),
            .subWdata(subWdata[32*gi+31:32*gi]),
            .subDone(subDone[gi]),
            .subError(subError[gi]),
            .subRdata(subRdata[32*gi+31:32*gi])
         );
      end
   endgenerate
endmodule

// File: fbib_consts.vh
// Shared constants of the fabric bus interface bridge
`ifndef FBIB_CONSTS_VH
`define FBIB_CONSTS_VH
`define FBIB_REGION_COUNT 6
`define FBIB_REGION0_TOP 4'h3
`define FBIB_REGION1_TOP 4'h5
`define FBIB_REGION2_TOP 4'h7
`define FBIB_REGION3_TOP 4'h8
`define FBIB_REGION4_TOP 4'h9
`define FBIB_REGION5_TOP 4'hF
`define FBIB_REGION_SPAN 32'h0FFFFFFF
`define FBIB_FABRIC_ADDR_W 20
`define FBIB_SIZE_BYTE 2'h0
`define FBIB_SIZE_HALF 2'h1
`define FBIB_SIZE_WORD 2'h2
`define FBIB_TRANS_IDLE 2'h0
`define FBIB_TRANS_BUSY 2'h1
`define FBIB_TRANS_NONSEQ 2'h2
`define FBIB_TRANS_SEQ 2'h3
`endif

// File: fbib_bridge_chk.sv
// Port-level assertions for the fabric bus interface bridge
`timescale 1ns/1ps
module fbib_bridge_chk
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Configuration and processor side
   input wire [5:0] regionToSecond,
   input wire [1:0] useApb,
   input wire reqValid,
   input wire reqReady,
   input wire [31:0] reqAddr,
   input wire [1:0] reqTrans,
   input wire respValid,
   input wire respError,
   // Master ports
   input wire [39:0] ahbAddr,
   input wire [3:0] hardMasterTransferType,
   input wire [1:0] ahbReady,
   input wire [1:0] apbSel,
   input wire [1:0] apbEnable,
   input wire [1:0] apbWrite,
   input wire [1:0] apbReady,
   input wire [1:0] periphMasterErrorIn,
   // Slave ports
   input wire [1:0] hsSel,
   input wire [1:0] hsReady,
   input wire [3:0] hardSlaveTransferType,
   input wire [1:0] hardSlaveReadyOut,
   input wire [1:0] hardSlaveResponse,
   input wire [1:0] subValid,
   input wire [1:0] subDone,
   input wire [1:0] subError
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_route;
      reqValid && reqReady && reqTrans[1] && reqAddr[31:28] == 4'h3 &&
      !regionToSecond[0] && !useApb[0] |=> hardMasterTransferType[1] &&
      ahbAddr[19:0] == $past(reqAddr[19:0]);
   endproperty
   a_route: assert property (p_route)
      else $error("region 0 request not forwarded");
   property p_unmapped;
      reqValid && reqAddr[31:28] == 4'h6 |=> respValid && respError;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped request not refused");
   property p_ahb_idle;
      hardMasterTransferType[1] && ahbReady[0]
      |=> hardMasterTransferType[1:0] == 2'h0;
   endproperty
   a_ahb_idle: assert property (p_ahb_idle)
      else $error("second transfer issued");
   property p_apb_rise;
      $rose(apbSel[0]) |-> !apbEnable[0];
   endproperty
   a_apb_rise: assert property (p_apb_rise)
      else $error("enable high in setup");
   property p_apb_step;
      apbSel[0] && !apbEnable[0] |=> apbSel[0] && apbEnable[0];
   endproperty
   a_apb_step: assert property (p_apb_step)
      else $error("access cycle missing");
   property p_apb_wait;
      apbEnable[0] && !apbReady[0] |=> apbEnable[0] && $stable(apbWrite[0]);
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("access ended before ready");
   property p_apb_err;
      apbEnable[0] && apbReady[0]
      |=> respValid && respError == $past(periphMasterErrorIn[0]);
   endproperty
   a_apb_err: assert property (p_apb_err)
      else $error("access error not reported");
   property p_slave_take;
      hsSel[0] && hsReady[0] && hardSlaveReadyOut[0] &&
      hardSlaveTransferType[1] |=> subValid[0] && !hardSlaveReadyOut[0];
   endproperty
   a_slave_take: assert property (p_slave_take)
      else $error("slave transfer not captured");
   property p_slave_sel;
      !hsSel[0] && !subValid[0] |=> !subValid[0];
   endproperty
   a_slave_sel: assert property (p_slave_sel)
      else $error("unselected transfer captured");
   property p_slave_err;
      subValid[0] && subDone[0] && subError[0] |=> hardSlaveResponse[0] &&
      !hardSlaveReadyOut[0] ##1 hardSlaveResponse[0] && hardSlaveReadyOut[0];
   endproperty
   a_slave_err: assert property (p_slave_err)
      else $error("slave error response wrong");
   cover property (apbEnable[0] && !apbReady[0]);
   cover property (respValid && respError);
   cover property (subValid[0] && subDone[0] && subError[0]);
endmodule
bind fbib_bridge fbib_bridge_chk fbib_bridge_chk_i (.*);

// File: fbib_fabric_model.sv
// Fabric slave model answering both master ports
`timescale 1ns/1ps
module fbib_fabric_model
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Wait states and error injection
   input wire [1:0] slow,
   input wire errOn,
   // Master port requests
   input wire [39:0] ahbAddr,
   input wire [3:0] hardMasterTransferType,
   input wire [39:0] apbAddr,
   input wire [1:0] apbSel,
   input wire [1:0] apbEnable,
   // Answers
   output reg [1:0] ahbReady,
   output reg [1:0] hardMasterResponse,
   output reg [63:0] ahbRdata,
   output reg [1:0] apbReady,
   output reg [1:0] periphMasterErrorIn,
   output reg [63:0] apbRdata
);
   reg [1:0] busy;
   reg [1:0] cnt [0:1];
   reg [19:0] adr [0:1];
   reg [31:0] tick;
   integer i, j;
   always @(posedge clk)
   begin
      tick <= rst ? 32'h0 : tick + 32'h1;
      for (i = 0; i < 2; i = i + 1)
      begin
         if (rst)
            busy[i] <= 1'b0;
         else if (!busy[i] && (hardMasterTransferType[2*i+1] ||
                  apbSel[i] && !apbEnable[i]))
         begin
            busy[i] <= 1'b1;
            cnt[i] <= slow;
            adr[i] <= apbSel[i] ? apbAddr[20*i+:20] : ahbAddr[20*i+:20];
         end
         else if (busy[i] && cnt[i] == 2'h0)
            busy[i] <= 1'b0;
         else if (busy[i])
            cnt[i] <= cnt[i] - 2'h1;
      end
   end
   // Data lines change every cycle outside the answering cycle
   always @*
   begin
      for (j = 0; j < 2; j = j + 1)
      begin
         ahbReady[j] = !busy[j] || cnt[j] == 2'h0;
         apbReady[j] = ahbReady[j];
         hardMasterResponse[j] = busy[j] && ahbReady[j] && errOn;
         periphMasterErrorIn[j] = hardMasterResponse[j];
         ahbRdata[32*j+:32] = busy[j] && ahbReady[j] ?
            {12'hC3A, adr[j]} : tick;
         apbRdata[32*j+:32] = ahbRdata[32*j+:32];
      end
   end
endmodule

// File: fbib_bridge_bench.sv
// Self-checking bench for the fabric bus interface bridge
`timescale 1ns/1ps
module fbib_bridge_bench;
   localparam [27:0] TOPS = 28'h6F98753;
   reg clk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
   reg reqLock = 1'b0, errOn = 1'b0, lk = 1'b0;
   reg [5:0] regionToSecond = 6'h0;
   reg [1:0] useApb = 2'h0, reqSize = 2'h0, reqTrans = 2'h0, slow = 2'h0;
   reg [1:0] hsSel = 2'h0, subDone = 2'h0, subError = 2'h0;
   reg [3:0] hardSlaveTransferType = 4'h0;
   reg [31:0] reqAddr = 32'h0, reqWdata = 32'h0;
   reg [63:0] hsAddr = 64'h0, subRdata = 64'h0;
   reg [63:0] hsWdata = 64'h0;
   reg [1:0] hardSlaveLock = 2'h0, hsWrite = 2'h0, hsReady = 2'h3, tk = 2'h0;
   reg [3:0] hsSize = 4'h2;
   wire reqReady, respValid, respError;
   wire [31:0] respRdata;
   wire [39:0] ahbAddr, apbAddr;
   wire [63:0] ahbWdata, ahbRdata, apbWdata, apbRdata, hsRdata;
   wire [63:0] subAddr, subWdata;
   wire [1:0] ahbLock, ahbWrite, ahbReady, hardMasterResponse, apbSel;
   wire [1:0] apbEnable, apbWrite, apbReady, periphMasterErrorIn;
   wire [1:0] hardSlaveReadyOut, hardSlaveResponse, subValid, subWrite;
   wire [1:0] subLock;
   wire [3:0] ahbSize, hardMasterTransferType, subSize;
   integer num_errors = 0, comparisons = 0, gN = 0, n, e, k, r, p;
   reg [19:0] gA;
   reg gP, gW, gL;
   reg [1:0] gS, gT, aph = 2'h0;
   reg [31:0] gD;
   fbib_bridge fbib_bridge_i (.*);
   fbib_fabric_model fbib_fabric_model_i (.*);
   always #4 clk = ~clk;
   // Record what each master port puts on the fabric
   always @(posedge clk)
   begin
      aph <= {hardMasterTransferType[3], hardMasterTransferType[1]} & ~useApb;
      for (p = 0; p < 2; p = p + 1)
      begin
         if (aph[p])
            gD <= ahbWdata[32*p+:32];
         if (useApb[p] ? apbSel[p] && !apbEnable[p] :
             hardMasterTransferType[2*p+1])
         begin
            gN <= gN + 1;
            gP <= p[0];
            gA <= useApb[p] ? apbAddr[20*p+:20] : ahbAddr[20*p+:20];
            gW <= useApb[p] ? apbWrite[p] : ahbWrite[p];
            gL <= ahbLock[p];
            gS <= ahbSize[2*p+:2];
            gT <= hardMasterTransferType[2*p+:2];
            if (useApb[p])
               gD <= apbWdata[32*p+:32];
         end
      end
   end
   task chk(input [79:0] nm, input [31:0] ex, input [31:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== ex)
         begin
            num_errors = num_errors + 1;
            $display("ERROR %0s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   // Read data the fabric model returns for a given port address
   function [31:0] exp_rdata(input [19:0] a);
      begin
         exp_rdata = {12'hC3A, a};
      end
   endfunction
   task req(input [31:0] a, input [1:0] t);
      begin
         reqAddr = a;
         reqTrans = t;
         reqWrite = $urandom;
         reqLock = $urandom;
         lk = reqLock;
         reqSize = $urandom % 3;
         reqWdata = $urandom;
         reqValid = 1'b1;
         for (k = 0; k < 20 && !reqReady; k = k + 1)
            @(negedge clk);
         @(negedge clk);
         reqValid = 1'b0;
         reqLock = 1'b0;
         for (k = 0; k < 40 && !respValid; k = k + 1)
            @(negedge clk);
         chk("respValid", 1, respValid);
      end
   endtask
   task tally_and_finish;
      begin
         if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial
   begin
      #200000;
      num_errors = num_errors + 1;
      tally_and_finish;
   end
   initial
   begin
      r = $urandom(32'h94a1bc87);
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (n = 0; n < 70; n = n + 1)
      begin
         r = n % 7;
         regionToSecond = $urandom;
         useApb = $urandom;
         slow = $urandom;
         errOn = $urandom % 4 == 0;
         e = gN;
         req({TOPS[4*r+:4], n < 7 ? 28'h0 : n < 14 ? 28'hFFFFFFF :
              28'($urandom)}, 2'h2 | 2'($urandom % 2));
         if (r == 6)
            chk("unmapped", 1, respError);
         else
         begin
            chk("captures", e + 1, gN);
            chk("port", regionToSecond[r], gP);
            chk("addr", reqAddr[19:0], gA);
            chk("write", reqWrite, gW);
            chk("error", errOn, respError);
            if (reqWrite)
               chk("wdata", reqWdata, gD);
            else if (!errOn)
               chk("rdata", exp_rdata(reqAddr[19:0]), respRdata);
            if (!useApb[gP])
               chk("ahb ctl", {lk, reqSize, reqTrans}, {gL, gS, gT});
         end
      end
      for (n = 0; n < 2; n = n + 1)
      begin
         e = gN;
         reqAddr = 32'h30000000;
         reqTrans = n[1:0];
         reqValid = 1'b1;
         repeat (4) @(negedge clk);
         reqValid = 1'b0;
         chk("ignored", e, gN + respValid);
      end
      for (n = 0; n < 12; n = n + 1)
      begin
         hsSel = $urandom;
         hsReady = n[0] ? 2'h3 : 2'($urandom);
         tk = hsSel & hsReady;
         hsAddr = {$urandom, $urandom};
         hsWdata = {$urandom, $urandom};
         hsWrite = $urandom;
         hardSlaveLock = $urandom;
         hsSize = {2'($urandom % 3), 2'($urandom % 3)};
         hardSlaveTransferType = 4'hA;
         @(negedge clk);
         hardSlaveTransferType = 4'h0;
         chk("subValid", tk, subValid);
         if (tk[1])
            chk("subAddr", hsAddr[63:32], subAddr[63:32]);
         if (tk[0])
            chk("subAddr", hsAddr[31:0], subAddr[31:0]);
         for (k = 0; k < 2; k = k + 1)
         begin
            chk("subWdata", hsWdata[32*k+:32], subWdata[32*k+:32]);
            if (tk[k])
            begin
               chk("subLock", hardSlaveLock[k], subLock[k]);
               chk("subWrite", hsWrite[k], subWrite[k]);
               chk("subSize", hsSize[2*k+:2], subSize[2*k+:2]);
            end
         end
         subError = $urandom;
         subRdata = {$urandom, $urandom};
         subDone = subValid;
         @(negedge clk);
         subDone = 2'h0;
         chk("slave rsp", {~(tk & subError), tk & subError},
             {hardSlaveReadyOut, hardSlaveResponse});
         if (tk[0] && !subError[0])
            chk("hsRdata", subRdata[31:0], hsRdata[31:0]);
         if (tk[1] && !subError[1])
            chk("hsRdata", subRdata[63:32], hsRdata[63:32]);
         @(negedge clk);
         chk("ready", 2'h3, hardSlaveReadyOut);
      end
      tally_and_finish;
   end
endmodule
